// File: fhc_map.svh
// Constants for the parallel flash host controller: pin bit positions,
// reset levels and timing counts.
// Assumes a 125 MHz system clock; all counts are derived from that period.
`ifndef FHC_MAP_SVH
`define FHC_MAP_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define FHC_CLK_NS        8
`define FHC_T_ACC_NS      70
`define FHC_T_WP_NS       40
`define FHC_T_RST_NS      500
`define FHC_T_REC_NS      50
`define FHC_T_PROT_US     100
`define FHC_T_UNPROT_MS   10
// Least times round up to whole cycles
`define FHC_ACC_CYC    ((`FHC_T_ACC_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_WP_CYC     ((`FHC_T_WP_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_RST_CYC    ((`FHC_T_RST_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_REC_CYC    ((`FHC_T_REC_NS + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_PROT_CYC   ((`FHC_T_PROT_US * 1000 + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_UNPROT_CYC ((`FHC_T_UNPROT_MS * 1000000 + `FHC_CLK_NS - 1) / `FHC_CLK_NS)
`define FHC_SYNC_STAGES   2

// ----------------------------------------------------------------------
// Address and data pin positions and fixed values
// ----------------------------------------------------------------------
`define FHC_A0_BIT        0
`define FHC_A1_BIT        1
`define FHC_A6_BIT        6
`define FHC_A12_BIT       12
`define FHC_A15_BIT       15
`define FHC_MSB_DQ_BIT    15
`define FHC_PIN_IDLE      1'b1
`define FHC_UPPER_ZERO    8'h00

`endif

// File: fhc_pkg.sv
// Types shared by the flash host controller files.
// Assumes fhc_map.svh carries all numeric constants.
package fhc_pkg;

  // ----------------------------------------------------------------------
  // Operations the user side may request
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FHC_OP_READ,
    FHC_OP_WRITE,
    FHC_OP_ID_READ,
    FHC_OP_PROT_VERIFY,
    FHC_OP_UNPROT_VERIFY,
    FHC_OP_PROTECT,
    FHC_OP_UNPROTECT,
    FHC_OP_RESET
  } fhc_op_t;

  // ----------------------------------------------------------------------
  // Bus sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    FHC_ST_IDLE,
    FHC_ST_READ,
    FHC_ST_WR_SETUP,
    FHC_ST_WR_PULSE,
    FHC_ST_WR_HOLD,
    FHC_ST_RESET,
    FHC_ST_RECOVER
  } fhc_state_t;

endpackage : fhc_pkg

// File: fhc_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes each bit is an independent level; words are only read when stable.
`timescale 1ns/1ns
`default_nettype none

module fhc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // Pin side
  input  wire logic [WIDTH-1:0] asyncIn,
  // Synchronised side
  output var  logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] syncOut_next;

  if (WIDTH < 1) begin : g_chk
    $error("fhc_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_comb begin
    meta_next    = asyncIn;
    syncOut_next = meta_reg;
  end

  // Both stages clear to zero; the pins settle within two cycles anyway
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_reg <= '0;
      syncOut  <= '0;
    end else begin
      meta_reg <= meta_next;
      syncOut  <= syncOut_next;
    end
  end

endmodule : fhc_sync

`default_nettype wire

// File: fhc_host.sv
// Host-side controller for an asynchronous parallel flash: drives the
// strobes, address, data and high-voltage qualifier pins for each request.
// Assumes one request at a time from the user side and board logic that
// turns each *Hv qualifier into the real high-voltage level on its pin.
`timescale 1ns/1ns
`default_nettype none
`include "fhc_map.svh"

// Summary of operation
// - Reads pull chip select and output drive low together.
// - Writes pull chip select and write strobe low with output drive high.
// - Protect raises id pin and output drive high, block address applied.
// - Protect pulse on write strobe lasts at least 100 microseconds.
// - Unprotect starts on a write strobe fall and takes 10ms.
// - Hard reset holds the reset pin low at least 500ns; data floats.
module fhc_host #(
  parameter int ACC_CYC    = `FHC_ACC_CYC,
  parameter int WP_CYC     = `FHC_WP_CYC,
  parameter int RST_CYC    = `FHC_RST_CYC,
  parameter int REC_CYC    = `FHC_REC_CYC,
  parameter int PROT_CYC   = `FHC_PROT_CYC,
  parameter int UNPROT_CYC = `FHC_UNPROT_CYC
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             srst,
  // User request side
  input  wire logic             reqValid,
  input  wire fhc_pkg::fhc_op_t reqOp,
  input  wire logic [17:0]      reqAddr,
  input  wire logic [15:0]      reqData,
  input  wire logic             byteMode,
  input  wire logic             tempUnprotect,
  output var  logic             reqReady,
  output var  logic             rspValid,
  output var  logic [15:0]      rspData,
  output var  logic             flashBusy,
  // Flash strobes and qualifiers
  output var  logic             flashCsN,
  output var  logic             flashCsHv,
  output var  logic             flashOeN,
  output var  logic             flashOeHv,
  output var  logic             flashWeN,
  output var  logic             hardResetN,
  output var  logic             hardResetHv,
  output var  logic             idModePinHv,
  output var  logic             widthSel,
  // Flash address and data
  output var  logic [16:0]      flashAddr,
  input  wire logic [15:0]      dqIn,
  output var  logic [15:0]      dqOut,
  output var  logic [15:0]      dqOe,
  input  wire logic             readyBusyN
);

  localparam int CW = 21;
  localparam int SYNC_WAIT = `FHC_SYNC_STAGES;

  // ----------------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------------
  if (ACC_CYC < 1 || WP_CYC < 1 || RST_CYC < 1 || REC_CYC < 1 ||
      PROT_CYC < 1 || UNPROT_CYC < 1 || UNPROT_CYC >= 2**CW ||
      PROT_CYC >= 2**CW || ACC_CYC + SYNC_WAIT >= 2**CW) begin : g_chk
    $error("fhc_host: timing count out of range");
  end

  fhc_pkg::fhc_state_t state_reg, state_next;
  fhc_pkg::fhc_op_t    op_reg, op_next;
  logic [CW-1:0]       cnt_reg, cnt_next;
  logic [17:0]         addr_reg, addr_next;
  logic [15:0]         data_reg, data_next, dqSync, rspData_next, dqOut_next, dqOe_next;
  logic [16:0]         syncBus, blockSelAddr, flashAddr_next;
  logic                busySync, hvOp, busOn, lsbAddrOrMsbData;
  logic                reqReady_next, rspValid_next, flashBusy_next, widthSel_next;
  logic                flashCsN_next, flashCsHv_next, flashOeN_next, flashOeHv_next;
  logic                flashWeN_next, hardResetN_next, hardResetHv_next, idModePinHv_next;

  // ----------------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------------
  fhc_sync #(
    .WIDTH   (17)
  ) u_sync (
    .sys_clk (sys_clk),
    .srst    (srst),
    .asyncIn ({!readyBusyN, dqIn}), // Inverted so cleared flops read as not busy
    .syncOut (syncBus)
  );
  assign busySync = syncBus[16];
  assign dqSync = syncBus[15:0];

  // Sequencer: one request runs to completion before the next is taken
  always_comb begin
    state_next    = state_reg;
    op_next       = op_reg;
    addr_next     = addr_reg;
    data_next     = data_reg;
    cnt_next      = (cnt_reg != '0) ? cnt_reg - CW'(1) : cnt_reg;
    rspValid_next = 1'b0;
    rspData_next  = rspData;
    unique case (state_reg)
      fhc_pkg::FHC_ST_IDLE: begin
        if (reqValid) begin
          op_next   = reqOp;
          addr_next = reqAddr;
          data_next = reqData;
          unique case (reqOp)
            fhc_pkg::FHC_OP_RESET: begin
              state_next = fhc_pkg::FHC_ST_RESET;
              cnt_next   = CW'(RST_CYC - 1);
            end
            fhc_pkg::FHC_OP_READ, fhc_pkg::FHC_OP_ID_READ,
            fhc_pkg::FHC_OP_PROT_VERIFY, fhc_pkg::FHC_OP_UNPROT_VERIFY: begin
              state_next = fhc_pkg::FHC_ST_READ;
              cnt_next   = CW'(ACC_CYC + SYNC_WAIT - 1); // Access plus sync lag
            end
            default: begin
              state_next = fhc_pkg::FHC_ST_WR_SETUP;
            end
          endcase
        end
      end
      fhc_pkg::FHC_ST_READ: begin
        if (cnt_reg == '0) begin
          rspValid_next = 1'b1;
          // Upper byte forced to zero in byte mode; device floats it there
          rspData_next  = byteMode ? {`FHC_UPPER_ZERO, dqSync[7:0]} : dqSync;
          state_next    = fhc_pkg::FHC_ST_RECOVER;
          cnt_next      = CW'(REC_CYC - 1);
        end
      end
      fhc_pkg::FHC_ST_WR_SETUP: begin
        state_next = fhc_pkg::FHC_ST_WR_PULSE;
        if (op_reg == fhc_pkg::FHC_OP_PROTECT) begin
          cnt_next = CW'(PROT_CYC - 1);
        end else if (op_reg == fhc_pkg::FHC_OP_UNPROTECT) begin
          cnt_next = CW'(UNPROT_CYC - 1);
        end else begin
          cnt_next = CW'(WP_CYC - 1);
        end
      end
      fhc_pkg::FHC_ST_WR_PULSE: begin
        if (cnt_reg == '0) begin
          state_next = fhc_pkg::FHC_ST_WR_HOLD;
        end
      end
      fhc_pkg::FHC_ST_WR_HOLD: begin
        state_next = fhc_pkg::FHC_ST_RECOVER;
        cnt_next   = CW'(REC_CYC - 1);
      end
      fhc_pkg::FHC_ST_RESET: begin
        if (cnt_reg == '0) begin
          state_next = fhc_pkg::FHC_ST_RECOVER;
          cnt_next   = CW'(REC_CYC - 1);
        end
      end
      fhc_pkg::FHC_ST_RECOVER: begin
        if (cnt_reg == '0) begin
          state_next = fhc_pkg::FHC_ST_IDLE;
        end
      end
    endcase
  end

  // Pin levels follow the next state so every pin comes from a flop
  always_comb begin
    hvOp  = (op_next == fhc_pkg::FHC_OP_PROTECT) ||
            (op_next == fhc_pkg::FHC_OP_UNPROTECT);
    busOn = (state_next == fhc_pkg::FHC_ST_READ) ||
            (state_next == fhc_pkg::FHC_ST_WR_SETUP) ||
            (state_next == fhc_pkg::FHC_ST_WR_PULSE) ||
            (state_next == fhc_pkg::FHC_ST_WR_HOLD);
    // Byte mode shifts the byte address down one bit; the top data pin takes the LSB
    blockSelAddr     = byteMode ? addr_next[17:1] : addr_next[16:0];
    lsbAddrOrMsbData = byteMode ? addr_next[0] : data_next[`FHC_MSB_DQ_BIT];
    unique case (op_next)
      fhc_pkg::FHC_OP_ID_READ: begin
        blockSelAddr[`FHC_A1_BIT] = 1'b0;
      end
      fhc_pkg::FHC_OP_PROT_VERIFY, fhc_pkg::FHC_OP_UNPROT_VERIFY: begin
        blockSelAddr[`FHC_A0_BIT] = 1'b0;
        blockSelAddr[`FHC_A1_BIT] = 1'b1;
        blockSelAddr[`FHC_A6_BIT] = (op_next == fhc_pkg::FHC_OP_UNPROT_VERIFY);
      end
      fhc_pkg::FHC_OP_UNPROTECT: begin
        blockSelAddr[`FHC_A12_BIT] = 1'b1;
        blockSelAddr[`FHC_A15_BIT] = 1'b1;
      end
      default: begin
      end
    endcase
    // Chip select stays high at idle so the device sits in standby
    flashCsN_next    = !busOn || (hvOp && op_next == fhc_pkg::FHC_OP_UNPROTECT);
    flashCsHv_next   = busOn && op_next == fhc_pkg::FHC_OP_UNPROTECT;
    flashOeN_next    = state_next != fhc_pkg::FHC_ST_READ;
    flashOeHv_next   = busOn && hvOp;
    flashWeN_next    = state_next != fhc_pkg::FHC_ST_WR_PULSE;
    idModePinHv_next = busOn && (hvOp || op_next == fhc_pkg::FHC_OP_ID_READ ||
                       op_next == fhc_pkg::FHC_OP_PROT_VERIFY ||
                       op_next == fhc_pkg::FHC_OP_UNPROT_VERIFY);
    hardResetN_next  = state_next != fhc_pkg::FHC_ST_RESET;
    // Temporary unprotect is a level the user holds across program or erase
    hardResetHv_next = tempUnprotect && hardResetN_next;
    widthSel_next    = !byteMode;
    flashAddr_next   = blockSelAddr;
    dqOut_next       = {lsbAddrOrMsbData, data_next[14:0]};
    // Drive data only during write phases; high-voltage ops carry none
    dqOe_next        = '0;
    if (busOn && state_next != fhc_pkg::FHC_ST_READ && !hvOp) begin
      dqOe_next = byteMode ? 16'h00FF : 16'hFFFF;
    end
    if (byteMode) begin
      dqOe_next[`FHC_MSB_DQ_BIT] = 1'b1; // Address LSB is always ours
    end
    reqReady_next  = state_next == fhc_pkg::FHC_ST_IDLE;
    flashBusy_next = busySync;
  end

  // State and pin registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg   <= fhc_pkg::FHC_ST_IDLE;
      op_reg      <= fhc_pkg::FHC_OP_READ;
      cnt_reg     <= '0;
      addr_reg    <= '0;
      data_reg    <= '0;
      reqReady    <= 1'b1;
      rspValid    <= 1'b0;
      rspData     <= '0;
      flashBusy   <= 1'b0;
      flashCsN    <= `FHC_PIN_IDLE;
      flashCsHv   <= 1'b0;
      flashOeN    <= `FHC_PIN_IDLE;
      flashOeHv   <= 1'b0;
      flashWeN    <= `FHC_PIN_IDLE;
      hardResetN  <= `FHC_PIN_IDLE;
      hardResetHv <= 1'b0;
      idModePinHv <= 1'b0;
      widthSel    <= `FHC_PIN_IDLE;
      flashAddr   <= '0;
      dqOut       <= '0;
      dqOe        <= '0;
    end else begin
      state_reg   <= state_next;
      op_reg      <= op_next;
      cnt_reg     <= cnt_next;
      addr_reg    <= addr_next;
      data_reg    <= data_next;
      reqReady    <= reqReady_next;
      rspValid    <= rspValid_next;
      rspData     <= rspData_next;
      flashBusy   <= flashBusy_next;
      flashCsN    <= flashCsN_next;
      flashCsHv   <= flashCsHv_next;
      flashOeN    <= flashOeN_next;
      flashOeHv   <= flashOeHv_next;
      flashWeN    <= flashWeN_next;
      hardResetN  <= hardResetN_next;
      hardResetHv <= hardResetHv_next;
      idModePinHv <= idModePinHv_next;
      widthSel    <= widthSel_next;
      flashAddr   <= flashAddr_next;
      dqOut       <= dqOut_next;
      dqOe        <= dqOe_next;
    end
  end

  // ----------------------------------------------------------------------
  // Checks on the pin behaviour
  // ----------------------------------------------------------------------
  logic [CW-1:0] weLowCnt;
  logic [CW-1:0] rstLowCnt;

  // Low-time counters seen only by the checks
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      weLowCnt  <= '0;
      rstLowCnt <= '0;
    end else begin
      weLowCnt  <= flashWeN ? '0 : weLowCnt + CW'(1);
      rstLowCnt <= hardResetN ? '0 : rstLowCnt + CW'(1);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  property p_read_strobes;
    $fell(flashOeN) |-> !flashCsN ##1 (!flashOeN && !flashCsN) [*2];
  endproperty
  a_read_strobes: assert property (p_read_strobes) else $error("read strobes");

  property p_write_oe_high;
    !flashWeN |-> flashOeN && dqOe[0] == !flashOeHv;
  endproperty
  a_write_oe_high: assert property (p_write_oe_high) else $error("write oe");

  property p_addr_setup;
    $fell(flashWeN) |-> $stable(flashAddr) && $past(!flashCsN || flashCsHv);
  endproperty
  a_addr_setup: assert property (p_addr_setup) else $error("addr setup");

  property p_data_hold;
    $rose(flashWeN) && !flashOeHv |-> $stable(dqOut) && dqOe[0] && !flashCsN;
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data hold");

  property p_release;
    !flashOeN |-> dqOe[14:0] == '0 ##1 (dqOe[14:0] == '0 || flashOeN);
  endproperty
  a_release: assert property (p_release) else $error("data not released");

  property p_prot_width;
    $rose(flashWeN) && flashOeHv |-> weLowCnt >= CW'(PROT_CYC);
  endproperty
  a_prot_width: assert property (p_prot_width) else $error("protect pulse");

  property p_reset_width;
    $rose(hardResetN) |-> rstLowCnt >= CW'(RST_CYC) && dqOe[7:0] == '0;
  endproperty
  a_reset_width: assert property (p_reset_width) else $error("reset pulse");

  property p_id_addr;
    !flashOeN && idModePinHv |-> flashAddr[`FHC_A1_BIT] == 1'b0 ||
      (flashAddr[`FHC_A1_BIT] && !flashAddr[`FHC_A0_BIT]);
  endproperty
  a_id_addr: assert property (p_id_addr) else $error("id address");

  property p_byte_upper;
    !widthSel |-> dqOe[14:8] == '0 && dqOe[`FHC_MSB_DQ_BIT];
  endproperty
  a_byte_upper: assert property (p_byte_upper) else $error("byte lanes");

  property p_hv_pair;
    flashOeHv |-> idModePinHv && flashOeN;
  endproperty
  a_hv_pair: assert property (p_hv_pair) else $error("hv pairing");

endmodule : fhc_host

`default_nettype wire

// File: fhc_flash_model.sv
// Behavioural model of the parallel flash device that the host controller drives.
// Assumes the bench resolves the shared data wires and feeds the level back on dqBus.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------------
// Flash device model
// ----------------------------------------------------------------------
module fhc_flash_model #(
  parameter int         T_ACC_NS  = 50,
  parameter int         T_PROT_NS = 160,   // Shared by protect and unprotect pulses
  parameter int         T_BUSY_NS = 200,
  parameter logic [7:0] MFR_CODE  = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_CODE  = 8'hC3  // Arbitrary value
) (
  // Strobes, with high-voltage qualifiers as separate inputs
  input  wire logic        csN,
  input  wire logic        csHv,
  input  wire logic        oeN,
  input  wire logic        oeHv,
  input  wire logic        weN,
  input  wire logic        hardResetN,
  input  wire logic        hardResetHv,
  input  wire logic        idModePinHv,
  input  wire logic        widthSel,
  // Address and data
  input  wire logic [16:0] addr,
  input  wire logic [15:0] dqBus,
  output var  logic [15:0] devDq,
  output var  logic [15:0] devOe,
  output var  logic        readyBusyN
);
  logic [15:0] mem [int];
  logic [31:0] prot    = '0;
  logic        sigMode = 1'b0;
  logic [16:0] latAddr;
  logic        latLsb;
  logic [15:0] word;
  logic [15:0] arr;
  logic [15:0] rdVal;
  realtime     tFall;
  // A write needs both strobes low with output drive high and no high voltage on the output drive or id pins
  wire  logic  wrAct = !csN && !weN && oeN && !oeHv && !idModePinHv;

  initial readyBusyN = 1'b1;

  // Address on the later falling strobe
  always @(posedge wrAct) begin
    latAddr = addr;
    latLsb  = dqBus[15];
  end

  // Data on the earlier rising strobe; programming only clears bits, like real cells
  always @(negedge wrAct) begin
    word = mem.exists(latAddr) ? mem[latAddr] : 16'hFFFF;
    if (hardResetN && readyBusyN) begin
      if (dqBus[7:0] == 8'h90) sigMode = 1'b1;
      else if (dqBus[7:0] == 8'hF0) sigMode = 1'b0;
      else if (!prot[latAddr[16:12]] || hardResetHv) begin
        if (widthSel) word = word & dqBus;
        else if (latLsb) word[15:8] = word[15:8] & dqBus[7:0];
        else word[7:0] = word[7:0] & dqBus[7:0];
        mem[latAddr] = word;
        readyBusyN = 1'b0;
        readyBusyN <= #(T_BUSY_NS) 1'b1;
      end
    end
  end

  // Protect and unprotect act on the rising strobe only if held low long enough
  always @(negedge weN) tFall = $realtime;
  always @(posedge weN) begin
    if ($realtime - tFall >= T_PROT_NS && oeHv && idModePinHv) begin
      if (!csN) prot[addr[16:12]] = 1'b1;
      else if (csHv && addr[12] && addr[15] && &prot) prot = '0;
    end
  end
  always @(negedge hardResetN) sigMode = 1'b0;

  // Read path: codes and protect status take over from array data
  always @* begin
    arr = mem.exists(addr) ? mem[addr] : 16'hFFFF;
    if ((idModePinHv || sigMode) && !addr[1]) rdVal = {8'h00, addr[0] ? DEV_CODE : MFR_CODE};
    else if (idModePinHv || sigMode) rdVal = {15'h0000, prot[addr[16:12]]};
    else if (widthSel) rdVal = arr;
    else rdVal = {8'h00, dqBus[15] ? arr[15:8] : arr[7:0]};
  end

  // Outputs keep the last data in automatic standby; floated when deselected or reset
  assign #(T_ACC_NS) devDq = rdVal;
  assign #(T_ACC_NS) devOe = (hardResetN && !csN && !oeN && weN) ?
                             (widthSel ? 16'hFFFF : 16'h00FF) : 16'h0000;
endmodule : fhc_flash_model
`default_nettype wire

// File: fhc_host_tb_top.sv
// Self-checking bench for fhc_host driving the behavioural flash model.
// Assumes fhc_pkg and fhc_flash_model are compiled before this file.
`timescale 1ns/1ns
`default_nettype none
`include "fhc_map.svh"

// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module fhc_host_tb_top;
  localparam int         PCYC = 20;    // Shortened protect pulses keep the run brief
  localparam logic [7:0] MFR  = 8'h5A; // Arbitrary value
  localparam logic [7:0] DEV  = 8'hC3; // Arbitrary value
  logic             sys_clk, srst, reqValid, byteMode, tempUnprotect;
  logic             reqReady, rspValid, flashBusy, readyBusyN, widthSel;
  logic             flashCsN, flashCsHv, flashOeN, flashOeHv, flashWeN;
  logic             hardResetN, hardResetHv, idModePinHv;
  fhc_pkg::fhc_op_t reqOp;
  logic [17:0]      reqAddr, a;
  logic [16:0]      flashAddr;
  logic [15:0]      reqData, rspData, dqIn, dqOut, dqOe, devDq, devOe, got, d;
  logic [15:0]      floatPat = 16'hA5A5;
  logic [15:0]      expMem [int];
  logic [31:0]      expProt = '0;
  int               nMismatch = 0, comparisons = 0, lowCnt = 0, lowStart, seed = 32'hd113;

  fhc_host #(.PROT_CYC(PCYC), .UNPROT_CYC(PCYC)) dut (
    .sys_clk(sys_clk), .srst(srst), .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqData(reqData), .byteMode(byteMode), .tempUnprotect(tempUnprotect),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .flashBusy(flashBusy),
    .flashCsN(flashCsN), .flashCsHv(flashCsHv), .flashOeN(flashOeN), .flashOeHv(flashOeHv),
    .flashWeN(flashWeN), .hardResetN(hardResetN), .hardResetHv(hardResetHv),
    .idModePinHv(idModePinHv), .widthSel(widthSel), .flashAddr(flashAddr), .dqIn(dqIn),
    .dqOut(dqOut), .dqOe(dqOe), .readyBusyN(readyBusyN));

  fhc_flash_model #(.T_PROT_NS(PCYC * 8), .MFR_CODE(MFR), .DEV_CODE(DEV)) flash (
    .csN(flashCsN), .csHv(flashCsHv), .oeN(flashOeN), .oeHv(flashOeHv), .weN(flashWeN),
    .hardResetN(hardResetN), .hardResetHv(hardResetHv), .idModePinHv(idModePinHv),
    .widthSel(widthSel), .addr(flashAddr), .dqBus(dqIn), .devDq(devDq), .devOe(devOe),
    .readyBusyN(readyBusyN));

  // Wire level; an undriven line wanders so stale data cannot pass
  always_comb begin
    for (int i = 0; i < 16; i++) dqIn[i] = dqOe[i] ? dqOut[i] : (devOe[i] ? devDq[i] : floatPat[i]);
  end

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Pin watch: no read and write strobes together, no host drive into a read
  always @(posedge sys_clk) begin
    floatPat <= ~floatPat;
    if (!hardResetN) lowCnt <= lowCnt + 1;
    if (!srst && !flashCsN && !flashWeN && !flashOeN) check(16'h0001, 16'h0000);
    if (!srst && !flashOeN && dqOe[14:0] != 15'h0000) check(dqOe, 16'h0000);
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] gotV, input logic [15:0] expV);
    comparisons++;
    if (gotV !== expV) begin
      nMismatch++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, gotV, expV);
    end
  endtask : check

  // Bounded wait, polled just after each edge
  task automatic waitLvl(ref logic sig, input logic lvl);
    int k;
    k = 0;
    while (sig !== lvl && k < 2000) begin
      @(posedge sys_clk);
      #1 k++;
    end
    if (k == 2000) begin
      check({15'h0000, sig}, {15'h0000, lvl});
      test_done();
    end
  endtask : waitLvl

  task automatic doReq(input fhc_pkg::fhc_op_t op, input logic [17:0] ad, input logic [15:0] dt,
                       output logic [15:0] rsp);
    rsp = 16'h0000;
    waitLvl(reqReady, 1'b1);
    reqOp    = op;
    reqAddr  = ad;
    reqData  = dt;
    reqValid = 1'b1;
    @(posedge sys_clk);
    #1 reqValid = 1'b0;
    if (op inside {fhc_pkg::FHC_OP_READ, fhc_pkg::FHC_OP_ID_READ, fhc_pkg::FHC_OP_PROT_VERIFY,
                   fhc_pkg::FHC_OP_UNPROT_VERIFY}) begin
      waitLvl(rspValid, 1'b1);
      rsp = rspData;
    end
    waitLvl(reqReady, 1'b1);
    waitLvl(flashBusy, 1'b0);
  endtask : doReq

  function automatic int wordAddr(input logic [17:0] ad);
    return byteMode ? int'(ad[17:1]) : int'(ad[16:0]);
  endfunction : wordAddr

  function automatic logic [15:0] expRead(input logic [17:0] ad);
    logic [15:0] w;
    w = expMem.exists(wordAddr(ad)) ? expMem[wordAddr(ad)] : 16'hFFFF;
    if (byteMode) return {8'h00, ad[0] ? w[15:8] : w[7:0]};
    return w;
  endfunction : expRead

  // Program then read back; a protected block keeps its old value
  task automatic rw(input logic [17:0] ad, input logic [15:0] dt);
    int          k;
    logic [15:0] w;
    k = wordAddr(ad);
    doReq(fhc_pkg::FHC_OP_WRITE, ad, dt, got);
    if (!expProt[k[16:12]] || tempUnprotect) begin
      w = expMem.exists(k) ? expMem[k] : 16'hFFFF;
      if (!byteMode) w = w & dt;
      else if (ad[0]) w[15:8] = w[15:8] & dt[7:0];
      else w[7:0] = w[7:0] & dt[7:0];
      expMem[k] = w;
    end
    doReq(fhc_pkg::FHC_OP_READ, ad, 16'h0000, got);
    check(got, expRead(ad));
  endtask : rw

  task automatic setMode(input logic m);
    byteMode = m;
    repeat (3) @(posedge sys_clk);
    #1 check({15'h0000, widthSel}, {15'h0000, !m});
  endtask : setMode

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    srst          = 1'b1;
    reqValid      = 1'b0;
    reqOp         = fhc_pkg::FHC_OP_READ;
    reqAddr       = '0;
    reqData       = '0;
    byteMode      = 1'b0;
    tempUnprotect = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 srst = 1'b0;
    check({11'h000, reqReady, flashCsN, flashOeN, flashWeN, hardResetN}, 16'h001F);
    check(dqOe, 16'h0000);
    // Random traffic in both organisations, first and last block included
    for (int i = 0; i < 20; i++) begin
      if (i == 12) setMode(1'b1);
      a = 18'($random(seed));
      if (i < 2) a[16:12] = i ? 5'h1F : 5'h00;
      d = 16'($random(seed)) & 16'hFF7F;
      rw(a, d);
    end
    // Codes by high-voltage pin and by the signature command, both widths
    for (int m = 1; m >= 0; m--) begin
      setMode(m[0]);
      for (int s = 0; s < 2; s++) begin
        a = 18'($random(seed));
        a[m] = s[0];
        doReq(fhc_pkg::FHC_OP_ID_READ, a, 16'h0000, got);
        check(got, {8'h00, s ? DEV : MFR});
      end
      doReq(fhc_pkg::FHC_OP_WRITE, 18'h00AAA, 16'h0090, got);
      for (int s = 0; s < 2; s++) begin
        a = 18'($random(seed));
        a[m] = s[0];
        a[m + 1] = 1'b0;
        doReq(fhc_pkg::FHC_OP_READ, a, 16'h0000, got);
        check(got, {8'h00, s ? DEV : MFR});
      end
      doReq(fhc_pkg::FHC_OP_WRITE, 18'h00AAA, 16'h00F0, got);
      a = 18'($random(seed));
      doReq(fhc_pkg::FHC_OP_READ, a, 16'h0000, got);
      check(got, expRead(a));
    end
    // Protect one block, verify it and a neighbour, then try writes
    a = 18'($random(seed));
    doReq(fhc_pkg::FHC_OP_PROTECT, a, 16'h0000, got);
    expProt[a[16:12]] = 1'b1;
    doReq(fhc_pkg::FHC_OP_PROT_VERIFY, a, 16'h0000, got);
    check(got, 16'h0001);
    doReq(fhc_pkg::FHC_OP_PROT_VERIFY, a ^ 18'h01000, 16'h0000, got);
    check(got, 16'h0000);
    rw(a, 16'h0000);
    tempUnprotect = 1'b1;
    rw(a ^ 18'h00001, 16'h0000);
    tempUnprotect = 1'b0;
    rw(a ^ 18'h00002, 16'h0000);
    // Unprotect needs every block protected first
    for (int b = 0; b < 32; b++) doReq(fhc_pkg::FHC_OP_PROTECT, {1'b0, 5'(b), 12'h000}, 16'h0000, got);
    doReq(fhc_pkg::FHC_OP_UNPROTECT, 18'h00000, 16'h0000, got);
    expProt = '0;
    for (int b = 0; b < 32; b += 5) begin
      doReq(fhc_pkg::FHC_OP_UNPROT_VERIFY, {1'b0, 5'(b), 12'h000}, 16'h0000, got);
      check(got, 16'h0000);
    end
    rw(a, 16'h0000);
    // Hard reset leaves signature mode and holds the pin low for the full count
    doReq(fhc_pkg::FHC_OP_WRITE, 18'h00AAA, 16'h0090, got);
    lowStart = lowCnt;
    doReq(fhc_pkg::FHC_OP_RESET, 18'h00000, 16'h0000, got);
    check(16'(lowCnt - lowStart), 16'(`FHC_RST_CYC));
    doReq(fhc_pkg::FHC_OP_READ, 18'h00000, 16'h0000, got);
    check(got, expRead(18'h00000));
    test_done();
  end
endmodule : fhc_host_tb_top
`default_nettype wire
